// [rtl/poe_port_defs.svh]
`ifndef POE_PORT_DEFS_SVH
`define POE_PORT_DEFS_SVH

// register indices on the plain port
`define REG_CONTROL 4'h0
`define REG_CAP_SET 4'h1
`define REG_OVL_SET 4'h2
`define REG_STATUS 4'h3
`define REG_FAULT 4'h4
`define REG_VOLT_LO 4'h5
`define REG_VOLT_HI 4'h6
`define REG_CURR_LO 4'h7
`define REG_CURR_HI 4'h8
`define REG_TIMERS 4'h9

// control register bits
`define CTL_ON_CMD 0
`define CTL_OFF_CMD 1
`define CTL_PORT_RESET 2
`define CTL_DC_DIS_EN 3
`define CTL_AC_DIS_EN 4
`define CTL_LOW_PRIO 5
`define CTL_DET_EN 6
`define CTL_CLS_EN 7
`define CTL_FAST_ADC 8
`define CTL_RESET 16'h0048

// fault bits
`define FLT_INRUSH 0
`define FLT_OVERLOAD 1
`define FLT_CAP 2
`define FLT_SWITCH 3
`define FLT_DISCONNECT 4
`define FLT_KILL 5
`define FLT_SHED 6

// cap code meaning 425mA (0.25 ohm sense)
`define CAP_DEFAULT 8'h80
`define OVL_DEFAULT 8'h00
`define FAST_MASK 8'he0

// times
`define CLK_MHZ 250
`define SWITCH_FAIL_NS 180000
`define SWITCH_FAIL_CYC (`SWITCH_FAIL_NS * `CLK_MHZ / 1000)
`define SHED_MAX_NS 6500
`define SHED_CYC ((`SHED_MAX_NS * `CLK_MHZ / 1000) > 1 ? 2 : 1)
// timer tick prescale (one tick per 1 us)
`define TICK_DIV 16'd249
`define DOWN_DIV 4'hf
// timer limits after reset, 50 ticks each
`define TMO_RESET 16'h3232

`endif

// [rtl/poe_port_pkg.sv]
package poe_port_pkg;
	typedef enum logic [2:0] {
		PORT_OFF,
		PORT_INRUSH,
		PORT_ON,
		PORT_FAILED
	} port_state_t;
endpackage

// [rtl/sat_timer.sv]
`timescale 1ns/100ps
`include "poe_port_defs.svh"

module sat_timer (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clr,
	input wire logic up,
	input wire logic down,
	input wire logic [15:0] limit,
	output logic expired,
	output logic [15:0] count
);
	typedef struct packed {
		logic [15:0] cnt;
	} st_t;
	st_t s, next_s;

	always_comb begin
		next_s = s;
		if (clr) begin
			next_s.cnt = 16'h0000;
		end else if (up && s.cnt != 16'hffff) begin
			next_s.cnt = s.cnt + 16'h0001;
		end else if (down && s.cnt != 16'h0000) begin
			next_s.cnt = s.cnt - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign count = s.cnt;
	assign expired = (s.cnt >= limit) && (limit != 16'h0000);
endmodule

// [rtl/poe_port_power_control.sv]
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/100ps
`include "poe_port_defs.svh"

module poe_port_power_control (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic port_kill_input_n,
	input wire logic priority_shed_input_n,
	input wire logic over_overload,
	input wire logic over_cap,
	input wire logic under_current,
	input wire logic charge_done,
	input wire logic switch_abnormal,
	input wire logic adc_valid,
	input wire logic [15:0] adc_volt,
	input wire logic [15:0] adc_curr,
	output logic gate_enable,
	output logic gate_ramp,
	output logic inrush_limit,
	output logic [7:0] cap_level,
	output logic weak_pulldown,
	output logic adc_fast,
	output logic readback_valid,
	output logic detect_enable,
	output logic class_enable
);
	typedef struct packed {
		poe_port_pkg::port_state_t state;
		logic [15:0] ctl;
		logic [7:0] cap_set;
		logic [7:0] ovl_set;
		logic [15:0] tmo;
		logic [7:0] fault;
		logic [15:0] volt;
		logic [15:0] curr;
		logic [15:0] rdata;
		logic [15:0] div;
		logic tick;
		logic [3:0] down_div;
		logic [15:0] fail_cnt;
		logic kill_hold;
	} st_t;
	st_t s, next_s;

	logic inr_exp, ovl_exp, cap_exp, dis_exp;
	logic [15:0] inr_cnt, ovl_cnt, cap_cnt, dis_cnt;
	logic powered, in_inrush, dis_en, shed;
	logic ovl_down;

	function automatic logic [15:0] fast_fix(input logic [15:0] v, input logic fast);
		fast_fix = fast ? {v[15:8], v[7:0] & `FAST_MASK} : v;
	endfunction

	assign powered = (s.state == poe_port_pkg::PORT_ON) || (s.state == poe_port_pkg::PORT_INRUSH);
	assign in_inrush = s.state == poe_port_pkg::PORT_INRUSH;
	assign dis_en = s.ctl[`CTL_DC_DIS_EN] | s.ctl[`CTL_AC_DIS_EN];
	assign shed = !priority_shed_input_n && s.ctl[`CTL_LOW_PRIO];
	assign ovl_down = !over_overload && s.tick && (s.down_div == `DOWN_DIV);

	sat_timer u_inrush_timer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clr(!in_inrush),
		.up(in_inrush && s.tick),
		.down(1'b0),
		.limit({8'h00, s.tmo[7:0]}),
		.expired(inr_exp),
		.count(inr_cnt)
	);

	sat_timer u_overload_timer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clr(!powered),
		.up(over_overload && s.tick),
		.down(ovl_down),
		.limit({8'h00, s.tmo[15:8]}),
		.expired(ovl_exp),
		.count(ovl_cnt)
	);

	sat_timer u_cap_active_timer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clr(!powered || !over_cap),
		.up(over_cap && s.tick),
		.down(1'b0),
		.limit({8'h00, s.tmo[15:8]}),
		.expired(cap_exp),
		.count(cap_cnt)
	);

	sat_timer u_undercurrent_timer (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clr(!powered || !under_current),
		.up(under_current && s.tick && (s.state == poe_port_pkg::PORT_ON)),
		.down(1'b0),
		.limit({8'h00, s.tmo[7:0]}),
		.expired(dis_exp),
		.count(dis_cnt)
	);

	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.div == `TICK_DIV) begin
			next_s.div = 16'h0000;
			next_s.tick = 1'b1;
			next_s.down_div = s.down_div + 4'h1;
		end else begin
			next_s.div = s.div + 16'h0001;
		end
		// command bits last one cycle after their write
		next_s.ctl[`CTL_ON_CMD] = 1'b0;
		next_s.ctl[`CTL_OFF_CMD] = 1'b0;
		next_s.ctl[`CTL_PORT_RESET] = 1'b0;
		// register writes
		if (wr) begin
			case (addr)
				`REG_CONTROL: next_s.ctl = wdata;
				`REG_CAP_SET: next_s.cap_set = wdata[7:0];
				`REG_OVL_SET: next_s.ovl_set = wdata[7:0];
				`REG_TIMERS: next_s.tmo = wdata;
				`REG_FAULT: next_s.fault = s.fault & ~wdata[7:0];
				default: ;
			endcase
		end
		// switch failure persistence
		if (switch_abnormal && s.state != poe_port_pkg::PORT_FAILED) begin
			next_s.fail_cnt = s.fail_cnt + 16'h0001;
		end else begin
			next_s.fail_cnt = 16'h0000;
		end
		if (!port_kill_input_n) begin
			next_s.kill_hold = 1'b1;
		end else if (wr && addr == `REG_CONTROL && wdata[`CTL_ON_CMD]) begin
			next_s.kill_hold = 1'b0;
		end
		case (s.state)
			poe_port_pkg::PORT_OFF: begin
				if (s.ctl[`CTL_ON_CMD] && !s.kill_hold && port_kill_input_n && !shed) begin
					next_s.state = poe_port_pkg::PORT_INRUSH;
				end
			end
			poe_port_pkg::PORT_INRUSH: begin
				if (charge_done) begin
					next_s.state = poe_port_pkg::PORT_ON;
				end else if (inr_exp) begin
					next_s.state = poe_port_pkg::PORT_OFF;
					next_s.fault[`FLT_INRUSH] = 1'b1;
				end
			end
			poe_port_pkg::PORT_ON: begin
				if (ovl_exp) begin
					next_s.state = poe_port_pkg::PORT_OFF;
					next_s.fault[`FLT_OVERLOAD] = 1'b1;
				end else if (cap_exp) begin
					next_s.state = poe_port_pkg::PORT_OFF;
					next_s.fault[`FLT_CAP] = 1'b1;
				end else if (dis_exp && dis_en) begin
					next_s.state = poe_port_pkg::PORT_OFF;
					next_s.fault[`FLT_DISCONNECT] = 1'b1;
				end
			end
			poe_port_pkg::PORT_FAILED: begin
				if (s.ctl[`CTL_PORT_RESET]) begin
					next_s.state = poe_port_pkg::PORT_OFF;
				end
			end
			default: next_s.state = poe_port_pkg::PORT_OFF;
		endcase
		if (s.state != poe_port_pkg::PORT_FAILED && powered) begin
			if (s.ctl[`CTL_OFF_CMD] || s.ctl[`CTL_PORT_RESET]) begin
				next_s.state = poe_port_pkg::PORT_OFF;
			end
			if (shed) begin
				next_s.state = poe_port_pkg::PORT_OFF;
				next_s.fault[`FLT_SHED] = 1'b1;
			end
			if (!port_kill_input_n) begin
				next_s.state = poe_port_pkg::PORT_OFF;
				next_s.fault[`FLT_KILL] = 1'b1;
			end
		end
		if (shed) begin
			next_s.ctl[`CTL_DET_EN] = 1'b0;
			next_s.ctl[`CTL_CLS_EN] = 1'b0;
		end
		if (s.fail_cnt >= 16'(`SWITCH_FAIL_CYC)) begin
			next_s.state = poe_port_pkg::PORT_FAILED;
			next_s.fault[`FLT_SWITCH] = 1'b1;
			next_s.fail_cnt = 16'h0000;
		end
		if (adc_valid) begin
			next_s.volt = fast_fix(adc_volt, s.ctl[`CTL_FAST_ADC]);
			next_s.curr = fast_fix(adc_curr, s.ctl[`CTL_FAST_ADC]);
		end
		next_s.rdata = 16'h0000;
		if (rd) begin
			case (addr)
				`REG_CONTROL: next_s.rdata = s.ctl;
				`REG_CAP_SET: next_s.rdata = {8'h00, s.cap_set};
				`REG_OVL_SET: next_s.rdata = {8'h00, s.ovl_set};
				`REG_STATUS: next_s.rdata = {14'h0000, powered, 1'(s.state)};
				`REG_FAULT: next_s.rdata = {8'h00, s.fault};
				`REG_VOLT_LO: next_s.rdata = powered ? {8'h00, s.volt[7:0]} : 16'h0000;
				`REG_VOLT_HI: next_s.rdata = powered ? {8'h00, s.volt[15:8]} : 16'h0000;
				`REG_CURR_LO: next_s.rdata = powered ? {8'h00, s.curr[7:0]} : 16'h0000;
				`REG_CURR_HI: next_s.rdata = powered ? {8'h00, s.curr[15:8]} : 16'h0000;
				`REG_TIMERS: next_s.rdata = s.tmo;
				default: next_s.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s <= '0;
			s.state <= poe_port_pkg::PORT_OFF;
			s.ctl <= `CTL_RESET;
			s.cap_set <= `CAP_DEFAULT;
			s.ovl_set <= `OVL_DEFAULT;
			s.tmo <= `TMO_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign gate_enable = powered;
	assign gate_ramp = in_inrush;
	assign inrush_limit = in_inrush;
	assign cap_level = (s.state == poe_port_pkg::PORT_ON) ? s.cap_set : `CAP_DEFAULT;
	assign weak_pulldown = s.state == poe_port_pkg::PORT_FAILED;
	assign adc_fast = s.ctl[`CTL_FAST_ADC];
	assign readback_valid = powered;
	assign detect_enable = s.ctl[`CTL_DET_EN] && s.state != poe_port_pkg::PORT_FAILED;
	assign class_enable = s.ctl[`CTL_CLS_EN] && s.state != poe_port_pkg::PORT_FAILED;
endmodule

// [tb/pd_model.sv]
`timescale 1ns/100ps
module pd_model (
	input wire logic ref_clk,
	input wire logic [2:0] mode,
	input wire logic gate_enable,
	input wire logic [15:0] vin,
	output logic over_overload,
	output logic over_cap,
	output logic under_current,
	output logic charge_done,
	output logic switch_abnormal,
	output logic adc_valid,
	output logic [15:0] adc_volt,
	output logic [15:0] adc_curr
);
	int cnt = 0;
	logic load;
	always_ff @(posedge ref_clk) begin
		cnt <= gate_enable ? cnt + 1 : 0;
	end
	// mode 1 is an open switch: output never charges
	assign charge_done = cnt > 20 && mode != 3'd1;
	assign load = cnt > 40;
	assign over_overload = load && mode == 3'd2;
	assign over_cap = load && mode == 3'd3;
	// mode 5 draws current in short bursts only
	assign under_current = load && (mode == 3'd4 || (mode == 3'd5 && cnt[6:0] != 7'h0));
	assign switch_abnormal = mode == 3'd6;
	assign adc_valid = cnt[5:0] == 6'h3f;
	assign adc_volt = vin;
	assign adc_curr = ~vin;
endmodule

// [tb/poe_port_properties.sv]
`timescale 1ns/100ps
module poe_port_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic port_kill_input_n,
	input wire logic priority_shed_input_n,
	input wire logic over_overload,
	input wire logic switch_abnormal,
	input wire logic gate_enable,
	input wire logic gate_ramp,
	input wire logic inrush_limit,
	input wire logic [7:0] cap_level,
	input wire logic weak_pulldown,
	input wire logic readback_valid,
	input wire logic detect_enable,
	input wire logic class_enable
);
	logic [16:0] ab_cnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// run length of abnormal switch sense
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !switch_abnormal)
			ab_cnt <= '0;
		else if (ab_cnt != '1)
			ab_cnt <= ab_cnt + 17'h1;
	end
	a_ramp_holds_inrush: assert property (gate_ramp |-> gate_enable && inrush_limit)
		else $error("ramp without inrush hold");
	a_inrush_cap: assert property (gate_ramp |-> cap_level == 8'h80)
		else $error("cap not default in inrush");
	a_off_cap: assert property (!gate_enable |-> cap_level == 8'h80)
		else $error("cap not default while off");
	a_readback_power: assert property (readback_valid |-> gate_enable)
		else $error("readback valid while unpowered");
	a_overload_grace: assert property ($rose(over_overload) && gate_enable && !gate_ramp |=> gate_enable)
		else $error("overload cut at once");
	a_kill_off: assert property (!port_kill_input_n |=> !gate_enable)
		else $error("port on during kill");
	a_shed_clear: assert property ($fell(gate_enable) && !priority_shed_input_n |-> ##[0:1] !detect_enable)
		else $error("detect left on after shed");
	a_fail_quiet: assert property (weak_pulldown |-> !gate_enable && !detect_enable && !class_enable)
		else $error("port active while failed");
	a_fail_late: assert property ($rose(weak_pulldown) |-> ab_cnt >= 17'd44990)
		else $error("switch fault too early");
	a_fail_due: assert property (ab_cnt == 17'd45100 |-> weak_pulldown)
		else $error("switch fault missing");
	c_inrush: cover property ($rose(gate_ramp));
	c_fail: cover property ($rose(weak_pulldown));
	c_shed: cover property ($fell(gate_enable) && !priority_shed_input_n);
endmodule
bind poe_port_power_control poe_port_checker chk_i (.ref_clk, .sys_rst, .port_kill_input_n,
	.priority_shed_input_n, .over_overload, .switch_abnormal, .gate_enable, .gate_ramp,
	.inrush_limit, .cap_level, .weak_pulldown, .readback_valid, .detect_enable, .class_enable);

// [tb/tb_poe_port_power_control.sv]
`timescale 1ns/100ps
`include "poe_port_defs.svh"
module tb_poe_port_power_control;
	logic ref_clk, sys_rst, wr, rd, port_kill_input_n, priority_shed_input_n;
	logic over_overload, over_cap, under_current, charge_done, switch_abnormal, adc_valid;
	logic gate_enable, gate_ramp, inrush_limit, weak_pulldown, adc_fast, readback_valid;
	logic detect_enable, class_enable;
	logic [3:0] addr;
	logic [7:0] cap_level;
	logic [2:0] mode;
	logic [15:0] wdata, rdata, adc_volt, adc_curr, vin;
	int err_total = 0;
	int tests_run = 0;
	int modes[7] = '{1, 2, 3, 4, 4, 4, 5};
	int ctls[7] = '{'h69, 'h69, 'h69, 'h69, 'h71, 'h61, 'h69};
	int bits[7] = '{0, 1, 2, 4, 4, -1, -1};
	poe_port_power_control dut (.ref_clk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata,
		.port_kill_input_n, .priority_shed_input_n, .over_overload, .over_cap, .under_current,
		.charge_done, .switch_abnormal, .adc_valid, .adc_volt, .adc_curr, .gate_enable,
		.gate_ramp, .inrush_limit, .cap_level, .weak_pulldown, .adc_fast, .readback_valid,
		.detect_enable, .class_enable);
	pd_model pd (.ref_clk, .mode, .gate_enable, .vin, .over_overload, .over_cap,
		.under_current, .charge_done, .switch_abnormal, .adc_valid, .adc_volt, .adc_curr);
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	task conclude();
		$display("tests_run %0d err_total %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task wreg(input logic [3:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
		#1;
	endtask
	task rchk(input logic [3:0] a, input logic [15:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task wait_gate(input logic v, input int n);
		for (int i = 0; i < n && gate_enable !== v; i++)
			step(1);
		if (gate_enable !== v) begin
			err_total++;
			conclude();
		end
	endtask
	task power_up(input logic [2:0] m, input logic [15:0] c);
		mode <= m;
		wreg(`REG_FAULT, 16'h007f);
		wreg(`REG_CONTROL, c);
		wait_gate(1'b1, 10);
		chk(gate_ramp, 1'b1);
		chk(cap_level, 8'h80);
	endtask
	initial begin
		void'($urandom(32'h2c5128ad));
		sys_rst = 1'b1;
		addr = 4'h0;
		wdata = 16'h0;
		wr = 1'b0;
		rd = 1'b0;
		port_kill_input_n = 1'b1;
		priority_shed_input_n = 1'b1;
		mode = 3'h0;
		vin = 16'($urandom);
		step(2);
		sys_rst <= 1'b0;
		step(1);
		chk(cap_level, 8'h80);
		rchk(`REG_CONTROL, 16'h0048);
		wreg(`REG_TIMERS, 16'h0202);
		wreg(`REG_CAP_SET, 16'h00c0);
		for (int t = 0; t < 7; t++) begin
			power_up(3'(modes[t]), 16'(ctls[t]));
			if (bits[t] >= 0) begin
				wait_gate(1'b0, 1000);
				rchk(`REG_FAULT, 16'(1 << bits[t]));
			end else begin
				step(2000);
				chk(gate_enable, 1'b1);
				wreg(`REG_CONTROL, 16'h0002);
				wait_gate(1'b0, 10);
			end
		end
		power_up(3'h0, 16'h0169);
		step(200);
		chk(cap_level, 8'hc0);
		chk(adc_fast, 1'b1);
		chk(readback_valid, 1'b1);
		rchk(`REG_VOLT_LO, {8'h0, vin[7:0] & 8'he0});
		rchk(`REG_VOLT_HI, {8'h0, vin[15:8]});
		port_kill_input_n <= 1'b0;
		step(2);
		chk(gate_enable, 1'b0);
		rchk(`REG_VOLT_LO, 16'h0);
		port_kill_input_n <= 1'b1;
		step(20);
		chk(gate_enable, 1'b0);
		power_up(3'h0, 16'h0069);
		step(100);
		priority_shed_input_n <= 1'b0;
		step(2);
		chk(gate_enable, 1'b0);
		chk(detect_enable, 1'b0);
		priority_shed_input_n <= 1'b1;
		mode <= 3'h6;
		wreg(`REG_FAULT, 16'h007f);
		step(45100);
		chk(weak_pulldown, 1'b1);
		rchk(`REG_FAULT, 16'h0008);
		mode <= 3'h0;
		wreg(`REG_CONTROL, 16'h0004);
		step(5);
		chk(weak_pulldown, 1'b0);
		conclude();
	end
endmodule
